/* File: pkg/lpm_pkg.sv */
// Package for the low-power mode sequencer: register map, fields, timing
package lpm_pkg;

    // ------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFF_CONFIG   = 8'h00;
    localparam logic [7:0] OFF_STATUS   = 8'h04;
    localparam logic [7:0] OFF_INT_STAT = 8'h08;
    localparam logic [7:0] OFF_INT_MASK = 8'h0C;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    // config_register_one
    localparam int CFG_SHORT_RECOVERY_SELECT_BIT  = 0;
    localparam int CFG_WDDIS_BIT  = 1;
    localparam int CFG_WIDTH      = 2;
    // Status / interrupt bits
    localparam int EV_WAIT_EXIT   = 0;
    localparam int EV_STOP_EXIT   = 1;
    localparam int EV_BREAK_LP    = 2;
    localparam int EV_WIDTH       = 3;

    localparam logic [CFG_WIDTH-1:0] CFG_RESET = 2'h0;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int RECOVERY_LONG  = 4096;
    localparam int RECOVERY_SHORT = 32;
    localparam int CNT_WIDTH      = 13;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        LPM_RUN,
        LPM_WAIT,
        LPM_STOP,
        LPM_RECOVER,
        LPM_STACK
    } lpm_state_t;

    typedef struct packed {
        logic wait_instr;
        logic stop_instr;
    } lpm_cpu_req_t;

    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic clockgen_output_en;
        logic cpu_halt_signal;
    } lpm_clk_ctl_t;

endpackage

/* File: hdl/lpm_sequencer.sv */
// Low-power mode sequencer: wait and stop entry, wake-up and recovery
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps

module lpm_sequencer #(
    parameter int RECOVERY_LONG_CYC  = lpm_pkg::RECOVERY_LONG,
    parameter int RECOVERY_SHORT_CYC = lpm_pkg::RECOVERY_SHORT
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    // CPU side
    input  wire lpm_pkg::lpm_cpu_req_t cpu_req,
    input  wire logic                  periph_irq,
    input  wire logic                  break_req,
    input  wire logic                  sys_reset_req,
    output logic                       stack_start,
    output logic                       clear_int_mask,
    output logic                       force_soft_trap_vector,
    output lpm_pkg::lpm_clk_ctl_t      clk_ctl,
    output logic                       operating_watchdog_en,
    // AXI4-Lite slave
    input  wire logic [7:0]            s_awaddr,
    input  wire logic                  s_awvalid,
    output logic                       s_awready,
    input  wire logic [31:0]           s_wdata,
    input  wire logic [3:0]            s_wstrb,
    input  wire logic                  s_wvalid,
    output logic                       s_wready,
    output logic [1:0]                 s_bresp,
    output logic                       s_bvalid,
    input  wire logic                  s_bready,
    input  wire logic [7:0]            s_araddr,
    input  wire logic                  s_arvalid,
    output logic                       s_arready,
    output logic [31:0]                s_rdata,
    output logic [1:0]                 s_rresp,
    output logic                       s_rvalid,
    input  wire logic                  s_rready,
    output logic                       irq
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam int CW = lpm_pkg::CNT_WIDTH;
    localparam int EW = lpm_pkg::EV_WIDTH;

    lpm_pkg::lpm_state_t          state_reg, state_next;
    logic [CW-1:0]                cnt_reg, cnt_next;
    logic [CW-1:0]                limit_reg, limit_next;
    logic                         brk_flag_reg, brk_flag_next;
    logic [lpm_pkg::CFG_WIDTH-1:0] cfg_reg, cfg_next;
    logic [EW-1:0]                ist_reg, ist_next;
    logic [EW-1:0]                imask_reg, imask_next;
    logic [EW-1:0]                ev;
    logic                         aw_got_reg, aw_got_next;
    logic                         w_got_reg, w_got_next;
    logic [7:0]                   awaddr_reg, awaddr_next;
    logic [31:0]                  wdata_reg, wdata_next;
    logic                         wstrb0_reg, wstrb0_next;
    logic                         bvalid_reg, bvalid_next;
    logic [1:0]                   bresp_reg, bresp_next;
    logic                         rvalid_reg, rvalid_next;
    logic [31:0]                  rdata_reg, rdata_next;
    logic [1:0]                   rresp_reg, rresp_next;
    logic                         stack_reg, stack_next;
    logic                         trap_reg, trap_next;
    logic                         clrm_reg, clrm_next;
    logic                         wr_fire;
    logic                         wake;

    // Recovery length in cycles from the select bit
    function automatic logic [CW-1:0] rec_len(input logic short_sel);
        rec_len = short_sel ? CW'(RECOVERY_SHORT_CYC)
                            : CW'(RECOVERY_LONG_CYC);
    endfunction

    // ------------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------------
    assign wake = periph_irq | break_req | sys_reset_req;

    always_comb begin
        state_next    = state_reg;
        cnt_next      = cnt_reg;
        limit_next    = limit_reg;
        stack_next    = 1'b0;
        trap_next     = 1'b0;
        clrm_next     = 1'b0;
        brk_flag_next = brk_flag_reg;
        ev            = '0;
        unique case (state_reg)
            lpm_pkg::LPM_RUN: begin
                cnt_next = '0;
                if (cpu_req.stop_instr) begin
                    state_next = lpm_pkg::LPM_STOP;
                    clrm_next  = 1'b1;
                end else if (cpu_req.wait_instr) begin
                    state_next = lpm_pkg::LPM_WAIT;
                    clrm_next  = 1'b1;
                end
            end
            lpm_pkg::LPM_WAIT: begin
                if (wake) begin
                    state_next       = lpm_pkg::LPM_STACK;
                    ev[lpm_pkg::EV_WAIT_EXIT] = 1'b1;
                    if (break_req) begin
                        brk_flag_next = 1'b1;
                        ev[lpm_pkg::EV_BREAK_LP] = 1'b1;
                    end
                end
            end
            lpm_pkg::LPM_STOP: begin
                cnt_next = '0;
                if (wake) begin
                    state_next = lpm_pkg::LPM_RECOVER;
                    limit_next = rec_len(
                        cfg_reg[lpm_pkg::CFG_SHORT_RECOVERY_SELECT_BIT]);
                    if (break_req) begin
                        brk_flag_next = 1'b1;
                        ev[lpm_pkg::EV_BREAK_LP] = 1'b1;
                    end
                end
            end
            lpm_pkg::LPM_RECOVER: begin
                cnt_next = cnt_reg + CW'(1);
                if (cnt_reg == limit_reg - CW'(1)) begin
                    state_next = lpm_pkg::LPM_STACK;
                    ev[lpm_pkg::EV_STOP_EXIT] = 1'b1;
                end
            end
            lpm_pkg::LPM_STACK: begin
                state_next = lpm_pkg::LPM_RUN;
                stack_next = 1'b1;
                trap_next  = brk_flag_reg;
            end
            default: state_next = lpm_pkg::LPM_RUN;
        endcase
        if (sys_reset_req) begin
            state_next = lpm_pkg::LPM_RUN;
            stack_next = 1'b0;
        end
        if (state_reg == lpm_pkg::LPM_RUN && break_req) begin
            trap_next = 1'b1;
        end
        // Flag cleared by software write of one; set wins
        if (wr_fire && awaddr_reg == lpm_pkg::OFF_STATUS
            && wdata_reg[lpm_pkg::EV_BREAK_LP] && wstrb0_reg) begin
            brk_flag_next = 1'b0;
        end
        if (ev[lpm_pkg::EV_BREAK_LP]) begin
            brk_flag_next = 1'b1;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg    <= lpm_pkg::LPM_RUN;
            cnt_reg      <= '0;
            limit_reg    <= '0;
            stack_reg    <= 1'b0;
            trap_reg     <= 1'b0;
            clrm_reg     <= 1'b0;
            brk_flag_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            limit_reg    <= limit_next;
            stack_reg    <= stack_next;
            trap_reg     <= trap_next;
            clrm_reg     <= clrm_next;
            brk_flag_reg <= brk_flag_next;
        end
    end

    always_comb begin
        clk_ctl.cpu_clk_en = state_reg == lpm_pkg::LPM_RUN
                          || state_reg == lpm_pkg::LPM_STACK;
        clk_ctl.periph_clk_en = state_reg != lpm_pkg::LPM_STOP
                             && state_reg != lpm_pkg::LPM_RECOVER;
        clk_ctl.clockgen_output_en = clk_ctl.periph_clk_en;
        clk_ctl.cpu_halt_signal = !clk_ctl.cpu_clk_en;
    end

    assign stack_start            = stack_reg;
    assign force_soft_trap_vector = trap_reg;
    assign clear_int_mask         = clrm_reg;
    // Watchdog keeps running in wait unless option disables it
    assign operating_watchdog_en  =
        !cfg_reg[lpm_pkg::CFG_WDDIS_BIT]
        && clk_ctl.periph_clk_en;

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    always_comb begin
        ist_next   = ist_reg;
        imask_next = imask_reg;
        cfg_next   = cfg_reg;
        if (wr_fire && wstrb0_reg) begin
            unique case (awaddr_reg)
                lpm_pkg::OFF_CONFIG:
                    cfg_next = wdata_reg[lpm_pkg::CFG_WIDTH-1:0];
                lpm_pkg::OFF_INT_STAT:
                    ist_next = ist_reg & ~wdata_reg[EW-1:0];
                lpm_pkg::OFF_INT_MASK:
                    imask_next = wdata_reg[EW-1:0];
                default: ;
            endcase
        end
        ist_next = ist_next | ev;
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ist_reg   <= '0;
            imask_reg <= '0;
            cfg_reg   <= lpm_pkg::CFG_RESET;
        end else begin
            ist_reg   <= ist_next;
            imask_reg <= imask_next;
            cfg_reg   <= cfg_next;
        end
    end

    assign irq = |(ist_reg & imask_reg);

    // ------------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------------
    assign wr_fire = aw_got_reg && w_got_reg && !bvalid_reg;

    function automatic logic addr_ok(input logic [7:0] a);
        addr_ok = a == lpm_pkg::OFF_CONFIG || a == lpm_pkg::OFF_STATUS
               || a == lpm_pkg::OFF_INT_STAT
               || a == lpm_pkg::OFF_INT_MASK;
    endfunction

    always_comb begin
        aw_got_next = aw_got_reg;
        w_got_next  = w_got_reg;
        awaddr_next = awaddr_reg;
        wdata_next  = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next  = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next  = rdata_reg;
        rresp_next  = rresp_reg;
        if (s_awvalid && s_awready) begin
            aw_got_next = 1'b1;
            awaddr_next = s_awaddr;
        end
        if (s_wvalid && s_wready) begin
            w_got_next = 1'b1;
            wdata_next = s_wdata;
            wstrb0_next = s_wstrb[0];
        end
        if (wr_fire) begin
            aw_got_next = 1'b0;
            w_got_next  = 1'b0;
            bvalid_next = 1'b1;
            bresp_next  = addr_ok(awaddr_reg) ? lpm_pkg::RESP_OKAY
                                              : lpm_pkg::RESP_SLVERR;
        end else if (bvalid_reg && s_bready) begin
            bvalid_next = 1'b0;
        end
        if (s_arvalid && s_arready) begin
            rvalid_next = 1'b1;
            rresp_next  = lpm_pkg::RESP_OKAY;
            rdata_next  = '0;
            unique case (s_araddr)
                lpm_pkg::OFF_CONFIG:
                    rdata_next[lpm_pkg::CFG_WIDTH-1:0] = cfg_reg;
                lpm_pkg::OFF_STATUS: begin
                    rdata_next[lpm_pkg::EV_BREAK_LP] = brk_flag_reg;
                    rdata_next[8 +: 3] = state_reg;
                end
                lpm_pkg::OFF_INT_STAT: rdata_next[EW-1:0] = ist_reg;
                lpm_pkg::OFF_INT_MASK: rdata_next[EW-1:0] = imask_reg;
                default: rresp_next = lpm_pkg::RESP_SLVERR;
            endcase
        end else if (rvalid_reg && s_rready) begin
            rvalid_next = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            aw_got_reg <= 1'b0;
            w_got_reg  <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg  <= '0;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg  <= '0;
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= '0;
        end else begin
            aw_got_reg <= aw_got_next;
            w_got_reg  <= w_got_next;
            awaddr_reg <= awaddr_next;
            wdata_reg  <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg  <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            rresp_reg  <= rresp_next;
        end
    end

    assign s_awready = !aw_got_reg && !bvalid_reg;
    assign s_wready  = !w_got_reg && !bvalid_reg;
    assign s_bvalid  = bvalid_reg;
    assign s_bresp   = bresp_reg;
    assign s_arready = !rvalid_reg;
    assign s_rvalid  = rvalid_reg;
    assign s_rdata   = rdata_reg;
    assign s_rresp   = rresp_reg;

endmodule

/* File: sim/lpm_cpu_model.sv */
// CPU-side model: turns bench commands into one-cycle instruction strobes
`timescale 1ns/1ps
module lpm_cpu_model (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic [1:0]            cmd,
    output lpm_pkg::lpm_cpu_req_t      cpu_req
);
    // ------------------------------------------------------------
    // Strobes: 1 wait, 2 stop, one clock each
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cpu_req <= '0;
        end else begin
            cpu_req.wait_instr <= (cmd == 2'h1);
            cpu_req.stop_instr <= (cmd == 2'h2);
        end
    end
endmodule

/* File: sim/lpm_seq_props.sv */
// Concurrent checks on the low-power sequencer ports
`timescale 1ns/1ps
module lpm_seq_props (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire lpm_pkg::lpm_cpu_req_t cpu_req,
    input wire logic                  periph_irq,
    input wire logic                  break_req,
    input wire logic                  sys_reset_req,
    input wire logic                  stack_start,
    input wire logic                  clear_int_mask,
    input wire logic                  force_soft_trap_vector,
    input wire lpm_pkg::lpm_clk_ctl_t clk_ctl,
    input wire logic                  operating_watchdog_en,
    input wire logic                  s_bvalid,
    input wire logic                  s_bready
);
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic in_wait;
    logic strobe;
    assign in_wait = clk_ctl.periph_clk_en && !clk_ctl.cpu_clk_en;
    assign strobe = cpu_req.wait_instr || cpu_req.stop_instr;
    sequence s_resume;
        clk_ctl.cpu_clk_en ##1 stack_start;
    endsequence
    sequence s_trap_resume;
        clk_ctl.cpu_clk_en ##1 (stack_start && force_soft_trap_vector);
    endsequence
    a_wait_irq_wake: assert property (in_wait && periph_irq && !break_req
        && !sys_reset_req |=> s_resume) else $error("wait wake late");
    a_wait_break_wake: assert property (in_wait && break_req
        && !sys_reset_req |=> s_trap_resume) else $error("break wake bad");
    a_halt_inverse: assert property (clk_ctl.cpu_halt_signal
        == !clk_ctl.cpu_clk_en) else $error("halt not inverse");
    a_clockgen_gate: assert property (clk_ctl.clockgen_output_en
        == clk_ctl.periph_clk_en) else $error("clockgen mismatch");
    a_stop_entry: assert property (cpu_req.stop_instr && clk_ctl.cpu_clk_en
        |=> !clk_ctl.clockgen_output_en && !clk_ctl.cpu_clk_en)
        else $error("stop entry clocks");
    a_mask_clear: assert property (strobe && clk_ctl.cpu_clk_en
        |=> clear_int_mask) else $error("mask clear missing");
    a_reset_exit: assert property (!clk_ctl.cpu_clk_en && sys_reset_req
        |=> (clk_ctl.cpu_clk_en && !stack_start) [*2])
        else $error("reset exit bad");
    a_watchdog_run: assert property (operating_watchdog_en
        |-> clk_ctl.periph_clk_en) else $error("watchdog while stopped");
    a_stack_pulse: assert property (stack_start |=> !stack_start)
        else $error("stack pulse long");
    a_bresp_stand: assert property (s_bvalid && !s_bready |=> $stable(s_bvalid))
        else $error("bvalid dropped");
endmodule

bind lpm_sequencer lpm_seq_props u_lpm_seq_props (.clock, .rst, .cpu_req,
    .periph_irq, .break_req, .sys_reset_req, .stack_start, .clear_int_mask,
    .force_soft_trap_vector, .clk_ctl, .operating_watchdog_en, .s_bvalid,
    .s_bready);

/* File: sim/lpm_sequencer_tb.sv */
// Self-checking testbench for the low-power mode sequencer
`timescale 1ns/1ps
module lpm_sequencer_tb;
    localparam int LONG_CYC = 64;
    logic                  clock = 1'b0;
    logic                  rst = 1'b1;
    logic [1:0]            cmd = 2'h0;
    lpm_pkg::lpm_cpu_req_t cpu_req;
    lpm_pkg::lpm_clk_ctl_t clk_ctl;
    logic                  periph_irq = 1'b0;
    logic                  break_req = 1'b0;
    logic                  sys_reset_req = 1'b0;
    logic                  stack_start, clear_int_mask, irq;
    logic                  force_soft_trap_vector, operating_watchdog_en;
    logic [7:0]            s_awaddr = 8'h00;
    logic [7:0]            s_araddr = 8'h00;
    logic [31:0]           s_wdata = 32'h0000_0000;
    logic [3:0]            s_wstrb = 4'hf;
    logic                  s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
    logic                  s_arvalid = 1'b0, s_rready = 1'b0;
    logic                  s_awready, s_wready, s_bvalid;
    logic                  s_arready, s_rvalid;
    logic [1:0]            s_bresp, s_rresp;
    logic [31:0]           s_rdata;
    int                    errors = 0;
    int                    samples_checked = 0;
    int                    exp_q[$];

    always #12.5 clock = ~clock;

    lpm_cpu_model u_lpm_cpu_model (.clock, .rst, .cmd, .cpu_req);
    lpm_sequencer #(.RECOVERY_LONG_CYC(LONG_CYC)) u_lpm_sequencer (
        .clock, .rst, .cpu_req, .periph_irq, .break_req, .sys_reset_req,
        .stack_start, .clear_int_mask, .force_soft_trap_vector, .clk_ctl,
        .operating_watchdog_en, .s_awaddr, .s_awvalid, .s_awready, .s_wdata,
        .s_wstrb, .s_wvalid, .s_wready, .s_bresp, .s_bvalid, .s_bready,
        .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
        .s_rready, .irq);

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic final_report;
        if (errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic axw(input logic [7:0] a, input logic [31:0] d,
                       output logic [1:0] r);
        logic aw_hit;
        logic w_hit;
        @(posedge clock);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'b1;
        s_wvalid <= 1'b1;
        #1;
        while (s_awvalid || s_wvalid) begin
            aw_hit = s_awvalid && s_awready;
            w_hit = s_wvalid && s_wready;
            @(posedge clock);
            if (aw_hit) s_awvalid <= 1'b0;
            if (w_hit) s_wvalid <= 1'b0;
            #1;
        end
        // Late response acceptance exercises a held bvalid
        repeat ($urandom_range(0, 2)) @(posedge clock);
        s_bready <= 1'b1;
        #1;
        while (!s_bvalid) begin
            @(posedge clock);
            #1;
        end
        r = s_bresp;
        @(posedge clock);
        s_bready <= 1'b0;
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d,
                       output logic [1:0] r);
        @(posedge clock);
        s_araddr <= a;
        s_arvalid <= 1'b1;
        s_rready <= 1'b1;
        #1;
        while (!s_arready) begin
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        s_arvalid <= 1'b0;
        #1;
        while (!s_rvalid) begin
            @(posedge clock);
            #1;
        end
        d = s_rdata;
        r = s_rresp;
        @(posedge clock);
        s_rready <= 1'b0;
    endtask

    task automatic enter(input logic [1:0] m);
        @(posedge clock);
        cmd <= m;
        @(posedge clock);
        cmd <= 2'h0;
        @(posedge clock);
        #1;
        check(clear_int_mask, 1'b1);
        check(clk_ctl.cpu_clk_en, 1'b0);
    endtask

    // Counts edges from the wake event to the stack pulse
    task automatic wake_check(input logic trap);
        int n;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (!stack_start && n < 5000);
        check(32'(n), 32'(exp_q.pop_front()));
        check(force_soft_trap_vector, trap);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] d;
        logic [1:0]  r;
        int          wd;
        d = $urandom(77676);
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        axr(lpm_pkg::OFF_CONFIG, d, r);
        check(d, 32'h0000_0000);
        axw(8'h10, 32'hffff_ffff, r);
        check(r, lpm_pkg::RESP_SLVERR);
        axr(8'h10, d, r);
        check({d[29:0], r}, {30'h0, lpm_pkg::RESP_SLVERR});
        axw(lpm_pkg::OFF_INT_MASK, 32'h0000_0007, r);
        for (int k = 0; k < 3; k++) begin
            wd = (k == 0) ? $urandom_range(0, 1) : 0;
            axw(lpm_pkg::OFF_CONFIG,
                (k == 1) ? 32'h1 : 32'(wd * 2), r);
            enter((k == 0) ? 2'h1 : 2'h2);
            check(clk_ctl.periph_clk_en, k == 0);
            check(operating_watchdog_en, k == 0 && wd == 0);
            exp_q.push_back(k == 0 ? 2 : (k == 1 ? 32 : LONG_CYC) + 2);
            repeat ($urandom_range(1, 20)) @(posedge clock);
            periph_irq <= 1'b1;
            wake_check(1'b0);
            @(posedge clock);
            periph_irq <= 1'b0;
            #1;
            check(irq, 1'b1);
            axr(lpm_pkg::OFF_INT_STAT, d, r);
            check(d, (k == 0) ? 32'h1 : 32'h2);
            axw(lpm_pkg::OFF_INT_STAT, 32'h0000_0007, r);
            check(irq, 1'b0);
        end
        axw(lpm_pkg::OFF_INT_MASK, 32'h0000_0000, r);
        enter(2'h1);
        exp_q.push_back(2);
        @(posedge clock);
        break_req <= 1'b1;
        wake_check(1'b1);
        @(posedge clock);
        break_req <= 1'b0;
        axr(lpm_pkg::OFF_STATUS, d, r);
        check(d[2], 1'b1);
        check(irq, 1'b0);
        axw(lpm_pkg::OFF_INT_MASK, 32'h0000_0004, r);
        check(irq, 1'b1);
        axw(lpm_pkg::OFF_INT_STAT, 32'h0000_0007, r);
        axw(lpm_pkg::OFF_STATUS, 32'h0000_0004, r);
        axr(lpm_pkg::OFF_STATUS, d, r);
        check({d[2], irq}, 2'b00);
        enter(2'h2);
        repeat (3) @(posedge clock);
        sys_reset_req <= 1'b1;
        @(posedge clock);
        sys_reset_req <= 1'b0;
        #1;
        check({clk_ctl.clockgen_output_en, stack_start}, 2'b10);
        @(posedge clock);
        break_req <= 1'b1;
        @(posedge clock);
        break_req <= 1'b0;
        #1;
        check(force_soft_trap_vector, 1'b1);
        final_report();
    end

    initial begin
        repeat (20000) @(posedge clock);
        errors++;
        final_report();
    end
endmodule
